//--- hw/sart_pkg.sv
// Constants for the discoverable addressing and reset table block
package sart_pkg;

  // Register byte offsets on the plain register port
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_EFF = 8'h0c;
  localparam logic [7:0] OFF_RESP = 8'h10;
  localparam logic [7:0] OFF_TBL_6C = 8'h6c;
  localparam logic [7:0] OFF_TBL_C0 = 8'hc0;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DAT_LSB = 8;

  // Instruction codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_ENTER4 = 8'hb7;
  localparam logic [7:0] OP_EXIT4 = 8'he9;
  localparam logic [7:0] OP_RD_EXT = 8'hc8;
  localparam logic [7:0] OP_WR_EXT = 8'hc5;

  // Status register bit positions
  localparam int ST_ADDR4 = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_WEL = 2;
  localparam int ST_VWEL = 3;
  localparam int ST_VACT = 4;
  localparam int ST_EXT_LSB = 8;
  localparam int ST_SR1_LSB = 16;

  // Table contents, lowest byte address in the lowest bits
  localparam logic [6:0] T6C_SR1_KIND = 7'h69;
  localparam logic [0:0] T6C_RSVD7 = 1'h1;
  localparam logic [5:0] T6D_SOFT_RST = 6'h10;
  localparam logic [1:0] T6D_EXIT_LO = 2'h0;
  localparam logic [7:0] T6E_EXIT_HI = 8'hc0;
  localparam logic [7:0] T6F_ENTER = 8'h80;
  localparam logic [7:0] TC0_CMD4_SUP = 8'h00;
  localparam logic [23:0] TC0_UPPER = 24'hffffff;
  localparam logic [31:0] TBL_6C = {T6F_ENTER, T6E_EXIT_HI, T6D_EXIT_LO, T6D_SOFT_RST,
                                    T6C_RSVD7, T6C_SR1_KIND};
  localparam logic [31:0] TBL_C0 = {TC0_UPPER, TC0_CMD4_SUP};

  // Address segmenting: one 128 Mbit segment spans 24 byte address bits
  localparam int SEG_BITS = 24;

  // Reset values
  localparam logic [7:0] EXT_RST = 8'h00;
  localparam logic [7:0] SR1_NV_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

endpackage : sart_pkg

//--- hw/sart_sr1_if.sv
// Carrier between the core and the status register 1 store
`timescale 1ns/10ps
interface sart_sr1_if;
  logic wr;
  logic [7:0] data;
  logic wel;
  logic vwel;
  logic soft_rst;
  logic [7:0] sr1;
  logic vact;

  modport owner (input wr, input data, input wel, input vwel, input soft_rst,
                 output sr1, output vact);
  modport user (output wr, output data, output wel, output vwel, output soft_rst,
                input sr1, input vact);
endinterface : sart_sr1_if

//--- hw/sart_sr1.sv
// Status register 1 store: non-volatile copy with a volatile override
`timescale 1ns/10ps
module sart_sr1
  import sart_pkg::*;
#(
  parameter logic [7:0] NV_INIT = SR1_NV_RST
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  sart_sr1_if.owner bus
);

  typedef struct packed {
    logic [7:0] nv;
    logic [7:0] vol;
    logic vact;
  } sart_sr1_s;

  sart_sr1_s st_q;
  sart_sr1_s st_d;

  // Next state; soft reset drops the override but keeps the NV copy
  always_comb
  begin
    st_d = st_q;
    if (bus.soft_rst)
    begin
      st_d.vact = 1'b0;
    end
    else if (bus.wr && bus.vwel)
    begin
      st_d.vol = bus.data;
      st_d.vact = 1'b1;
    end
    else if (bus.wr && bus.wel)
    begin
      st_d.nv = bus.data;
    end
  end

  // Only rst_i stands for a power cycle; NV_INIT is the programmed value
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= '{nv: NV_INIT, vol: SR1_NV_RST, vact: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Override wins once activated
  assign bus.sr1 = st_q.vact ? st_q.vol : st_q.nv;
  assign bus.vact = st_q.vact;

  property p_nv_needs_wel;
    @(posedge clk_sys_i) disable iff (rst_i)
    (bus.wr && !bus.wel && !bus.vwel) |=> $stable(st_q.nv);
  endproperty
  a_nv_needs_wel: assert property (p_nv_needs_wel)
    else $error("NV status byte changed without write enable");

  property p_vol_override;
    @(posedge clk_sys_i) disable iff (rst_i)
    (bus.wr && bus.vwel && !bus.soft_rst) |=> (bus.vact && bus.sr1 == $past(bus.data));
  endproperty
  a_vol_override: assert property (p_vol_override)
    else $error("Volatile write did not override status byte");

endmodule : sart_sr1

//--- hw/sart_core.sv
// Addressing and reset table block with its command state
//
// Operation
// - Table byte 6Ch bits 6..0 return the fixed pattern for how status register 1 is written.
// - The non-volatile status copy is only written after write enable 06h and is kept over a soft reset.
// - After 50h a status write goes to the volatile copy, which then overrides the NV copy.
// - Reset enable 66h followed by reset 99h restores the default state, leaving 4-byte mode.
// - Table bits 13..8 return the fixed soft reset and rescue pattern.
// - Instruction E9h leaves 4-byte address mode without any write enable.
// - An 8-bit volatile extended address register is read by C8h and written by C5h.
// - In 3-byte mode the extended address register picks the active 128 Mbit segment.
// - Instruction B7h enters 4-byte address mode without any write enable.
// - Table bits 23..14 return the exit methods field as a fixed pattern.
// - Table bits 31..24 return the enter field, with its dedicated instruction set bit.
// - Table byte C0h returns zero in all eight dedicated 4-byte command support bits.
`timescale 1ns/10ps
module sart_core
  import sart_pkg::*;
#(
  parameter logic [7:0] NV_SR1_INIT = SR1_NV_RST
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic addr4_o,
  output logic [7:0] ext_addr_o,
  output logic [31:0] eff_addr_o
);

  typedef struct packed {
    logic addr4;
    logic armed;
    logic wel;
    logic vwel;
    logic [7:0] ext;
    logic [7:0] resp;
    logic [31:0] addr_in;
    logic [31:0] eff;
    logic [31:0] rdata;
  } sart_core_s;

  sart_core_s st_q;
  sart_core_s st_d;

  sart_sr1_if sr1_bus ();

  logic cmd_wr;
  logic [7:0] op;
  logic [7:0] dat;
  logic do_soft_rst;
  logic [31:0] status_word;

  // Command decode from a write to the command register
  assign cmd_wr = wr_i && (addr_i == OFF_CMD);
  assign op = wdata_i[CMD_OP_LSB +: 8];
  assign dat = wdata_i[CMD_DAT_LSB +: 8];
  assign do_soft_rst = cmd_wr && (op == OP_RST) && st_q.armed;

  // Status image of the command state
  always_comb
  begin
    status_word = WORD_RST;
    status_word[ST_ADDR4] = st_q.addr4;
    status_word[ST_ARMED] = st_q.armed;
    status_word[ST_WEL] = st_q.wel;
    status_word[ST_VWEL] = st_q.vwel;
    status_word[ST_VACT] = sr1_bus.vact;
    status_word[ST_EXT_LSB +: 8] = st_q.ext;
    status_word[ST_SR1_LSB +: 8] = sr1_bus.sr1;
  end

  // Hooks into the status register store
  assign sr1_bus.wr = cmd_wr && (op == OP_WRSR1);
  assign sr1_bus.data = dat;
  assign sr1_bus.wel = st_q.wel;
  assign sr1_bus.vwel = st_q.vwel;
  assign sr1_bus.soft_rst = do_soft_rst;

  sart_sr1 #(
    .NV_INIT(NV_SR1_INIT)
  ) u_sr1 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .bus(sr1_bus)
  );

  // Next state: instruction effects, address translation, read mux
  always_comb
  begin
    st_d = st_q;
    // Segment select uses the state before this cycle's commands
    if (st_q.addr4)
    begin
      st_d.eff = st_q.addr_in;
    end
    else
    begin
      st_d.eff = {st_q.ext, st_q.addr_in[SEG_BITS-1:0]};
    end
    if (wr_i && (addr_i == OFF_ADDR))
    begin
      st_d.addr_in = wdata_i;
    end
    if (cmd_wr)
    begin
      // Any command but 66h disarms the reset pair, 99h right after 66h included
      st_d.armed = (op == OP_RST_EN);
      case (op)
        OP_WREN:
        begin
          st_d.wel = 1'b1;
        end
        OP_VWREN:
        begin
          st_d.vwel = 1'b1;
        end
        OP_WRSR1:
        begin
          st_d.wel = 1'b0;
          st_d.vwel = 1'b0;
        end
        OP_RDSR1:
        begin
          st_d.resp = sr1_bus.sr1;
        end
        OP_ENTER4:
        begin
          st_d.addr4 = 1'b1;
        end
        OP_EXIT4:
        begin
          st_d.addr4 = 1'b0;
        end
        OP_WR_EXT:
        begin
          st_d.ext = dat;
        end
        OP_RD_EXT:
        begin
          st_d.resp = st_q.ext;
        end
        OP_RST:
        begin
          if (st_q.armed)
          begin
            // Back to power-on defaults, 3-byte addressing included
            st_d.addr4 = 1'b0;
            st_d.ext = EXT_RST;
            st_d.wel = 1'b0;
            st_d.vwel = 1'b0;
            st_d.resp = EXT_RST;
          end
        end
        default:
        begin
          st_d.armed = st_d.armed;
        end
      endcase
    end
    // Read data stand only in the cycle after the strobe
    st_d.rdata = WORD_RST;
    if (rd_i)
    begin
      case (addr_i)
        OFF_STAT: st_d.rdata = status_word;
        OFF_ADDR: st_d.rdata = st_q.addr_in;
        OFF_EFF: st_d.rdata = st_q.eff;
        OFF_RESP: st_d.rdata = {24'h000000, st_q.resp};
        OFF_TBL_6C: st_d.rdata = TBL_6C;
        OFF_TBL_C0: st_d.rdata = TBL_C0;
        default: st_d.rdata = WORD_RST;
      endcase
    end
  end

  // State register; power-on leaves 3-byte mode and segment zero
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= '{addr4: 1'b0, armed: 1'b0, wel: 1'b0, vwel: 1'b0, ext: EXT_RST,
                resp: EXT_RST, addr_in: WORD_RST, eff: WORD_RST, rdata: WORD_RST};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign addr4_o = st_q.addr4;
  assign ext_addr_o = st_q.ext;
  assign eff_addr_o = st_q.eff;

  // Assertion helpers
  sequence s_cmd(logic [7:0] code);
    cmd_wr && op == code;
  endsequence

  // Host leaves one idle cycle between commands; the arm must survive it
  sequence s_reset_pair;
    s_cmd(OP_RST_EN) ##1 !cmd_wr ##1 s_cmd(OP_RST);
  endsequence

  property p_soft_reset;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_reset_pair |=> (!addr4_o && ext_addr_o == EXT_RST && !st_q.wel);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("Reset pair did not restore defaults");

  property p_lone_reset;
    @(posedge clk_sys_i) disable iff (rst_i)
    (s_cmd(OP_RST) and (!st_q.armed && !$past(st_q.armed))) |=> $stable(ext_addr_o);
  endproperty
  a_lone_reset: assert property (p_lone_reset)
    else $error("Reset without enable took effect");

  property p_enter4;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_cmd(OP_ENTER4) |=> addr4_o;
  endproperty
  a_enter4: assert property (p_enter4)
    else $error("B7h did not enter 4-byte mode");

  property p_exit4;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_cmd(OP_EXIT4) |=> !addr4_o;
  endproperty
  a_exit4: assert property (p_exit4)
    else $error("E9h did not leave 4-byte mode");

  property p_ext_roundtrip;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_cmd(OP_WR_EXT) ##1 !cmd_wr ##1 s_cmd(OP_RD_EXT) |=> st_q.resp == $past(ext_addr_o);
  endproperty
  a_ext_roundtrip: assert property (p_ext_roundtrip)
    else $error("Extended address read back wrong");

  property p_ext_write;
    @(posedge clk_sys_i) disable iff (rst_i)
    (s_cmd(OP_WR_EXT) and !do_soft_rst) |=> ext_addr_o == $past(dat);
  endproperty
  a_ext_write: assert property (p_ext_write)
    else $error("C5h did not load extended address");

  property p_segment;
    @(posedge clk_sys_i) disable iff (rst_i)
    !addr4_o |=> eff_addr_o == {$past(ext_addr_o), $past(st_q.addr_in[SEG_BITS-1:0])};
  endproperty
  a_segment: assert property (p_segment)
    else $error("Segment select wrong in 3-byte mode");

  property p_tbl_6c;
    @(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == OFF_TBL_6C) |=> (rdata_o[6:0] == 7'h69 && rdata_o[13:8] == 6'h10);
  endproperty
  a_tbl_6c: assert property (p_tbl_6c)
    else $error("Table dword 6Ch wrong");

  property p_tbl_c0;
    @(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == OFF_TBL_C0) |=> (rdata_o[7:0] == 8'h00
                                        ##1 ($past(rd_i) || rdata_o == WORD_RST));
  endproperty
  a_tbl_c0: assert property (p_tbl_c0)
    else $error("Table byte C0h not all unsupported");

  property p_tbl_fields;
    @(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == OFF_TBL_6C) |=> (rdata_o[23:16] == 8'hc0 && rdata_o[31:24] == 8'h80
                                        && rdata_o[7]);
  endproperty
  a_tbl_fields: assert property (p_tbl_fields)
    else $error("Table exit or enter field wrong");

  // Read data fall back to zero so stale table words never linger
  property p_rdata_idle;
    @(posedge clk_sys_i) disable iff (rst_i)
    !rd_i |=> rdata_o == WORD_RST;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data stood without a read");

  // In 4-byte mode the full written address passes through
  property p_eff_4byte;
    @(posedge clk_sys_i) disable iff (rst_i)
    addr4_o |=> eff_addr_o == $past(st_q.addr_in);
  endproperty
  a_eff_4byte: assert property (p_eff_4byte)
    else $error("Effective address wrong in 4-byte mode");

  property p_wel_set;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_cmd(OP_WREN) |=> st_q.wel;
  endproperty
  a_wel_set: assert property (p_wel_set)
    else $error("06h did not set write enable");

  property p_vwel_set;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_cmd(OP_VWREN) |=> st_q.vwel;
  endproperty
  a_vwel_set: assert property (p_vwel_set)
    else $error("50h did not set volatile write enable");

endmodule : sart_core

//--- verif/sart_host_model.sv
// Host model: drives register accesses and command sequences
`timescale 1ns/10ps
module sart_host_model
  import sart_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [31:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // Idle bus at time zero
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One-cycle write; released bus shows inverted values, not stale ones
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr_reg

  // One-cycle read; data taken in the following cycle only
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd_reg

  task automatic cmd(input logic [7:0] op, input logic [7:0] dat);
    wr_reg(OFF_CMD, {16'h0000, dat, op});
  endtask : cmd

  // Write enable always precedes a non-volatile status write
  task automatic nv_write(input logic [7:0] v);
    cmd(OP_WREN, 8'h00);
    cmd(OP_WRSR1, v);
  endtask : nv_write

  // Volatile enable activates the overriding copy
  task automatic v_write(input logic [7:0] v);
    cmd(OP_VWREN, 8'h00);
    cmd(OP_WRSR1, v);
  endtask : v_write

  task automatic soft_reset();
    cmd(OP_RST_EN, 8'h00);
    cmd(OP_RST, 8'h00);
  endtask : soft_reset

  // Mode changes need no write enable; lowest segment is ext 00h
  task automatic enter4();
    cmd(OP_ENTER4, 8'h00);
  endtask : enter4

  task automatic exit4();
    cmd(OP_EXIT4, 8'h00);
  endtask : exit4

  task automatic seg_low();
    cmd(OP_WR_EXT, 8'h00);
  endtask : seg_low
endmodule : sart_host_model

//--- verif/testbench.sv
// Self-checking bench for the addressing and reset table block
`timescale 1ns/10ps
module testbench
  import sart_pkg::*;
;
  localparam logic [7:0] NV_INIT = 8'ha5;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] v;
  logic wr;
  logic rd;
  logic addr4;
  logic [7:0] ext;
  logic [31:0] eff;
  int err_count = 0;
  int check_count = 0;

  // Free-running 50 MHz clock
  initial
  begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  sart_core #(.NV_SR1_INIT(NV_INIT)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .addr4_o(addr4), .ext_addr_o(ext), .eff_addr_o(eff));

  sart_host_model u_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    u_host.rd_reg(a, v);
    check(v, exp);
  endtask : rc

  // Lets the one-cycle lag of the effective address land
  task automatic settle();
    @(posedge clk_sys_i);
    #1;
  endtask : settle

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    summarize();
  end

  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    check({23'h0, addr4, ext}, 32'h0);
    check(eff, 32'h0);
    rc(OFF_STAT, {8'h00, NV_INIT, 16'h0000});
    settle();
    check(rdata, 32'h0);
    $display("test reset done");
    // Table dwords built field by field, reserved bits as ones
    rc(OFF_TBL_6C, {8'h80, 8'hc0, 2'h0, 6'h10, 1'h1, 7'h69});
    u_host.wr_reg(OFF_TBL_6C, 32'h0000_0000);
    rc(OFF_TBL_6C, 32'h80c0_10e9);
    rc(OFF_TBL_C0, {24'hffffff, 8'b0000_0000});
    rc(8'h40, 32'h0);
    $display("test table done");
    u_host.enter4();
    #1 check({31'h0, addr4}, 32'h1);
    u_host.cmd(OP_RST, 8'h00);
    #1 check({31'h0, addr4}, 32'h1);
    u_host.exit4();
    #1 check({31'h0, addr4}, 32'h0);
    $display("test mode done");
    u_host.cmd(OP_WR_EXT, 8'h12);
    #1 check({24'h0, ext}, 32'h12);
    u_host.cmd(OP_RD_EXT, 8'h00);
    rc(OFF_RESP, 32'h12);
    u_host.wr_reg(OFF_ADDR, 32'h0034_5678);
    settle();
    check(eff, 32'h1234_5678);
    u_host.enter4();
    u_host.wr_reg(OFF_ADDR, 32'habcd_ef01);
    settle();
    check(eff, 32'habcd_ef01);
    u_host.exit4();
    settle();
    check(eff, 32'h12cd_ef01);
    u_host.seg_low();
    settle();
    check(eff, 32'h00cd_ef01);
    $display("test segment done");
    u_host.enter4();
    u_host.cmd(OP_WR_EXT, 8'h34);
    u_host.cmd(OP_RST_EN, 8'h00);
    u_host.cmd(OP_RDSR1, 8'h00);
    u_host.cmd(OP_RST, 8'h00);
    #1 check({23'h0, addr4, ext}, 32'h134);
    u_host.soft_reset();
    #1 check({23'h0, addr4, ext}, 32'h0);
    $display("test soft reset done");
    u_host.cmd(OP_WRSR1, 8'h11);
    rc(OFF_STAT, {8'h00, NV_INIT, 16'h0000});
    u_host.nv_write(8'h5a);
    rc(OFF_STAT, 32'h005a_0000);
    u_host.v_write(8'h3c);
    rc(OFF_STAT, 32'h003c_0010);
    u_host.cmd(OP_RDSR1, 8'h00);
    rc(OFF_RESP, 32'h3c);
    u_host.soft_reset();
    rc(OFF_STAT, 32'h005a_0000);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rc(OFF_STAT, {8'h00, NV_INIT, 16'h0000});
    $display("test status done");
    summarize();
  end
endmodule : testbench
